// >>> src/usb_irq_pkg.sv
// Package: register map, bit positions and reset values of the USB interrupt and error-flag block.
// Assumes a byte-wide register port with the documented offsets used as register indices.
package usb_irq_pkg;

   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [8:0] OFF_IRQ_FLAGS   = 9'h190;
   localparam logic [8:0] OFF_IRQ_ENABLE  = 9'h191;
   localparam logic [8:0] OFF_ERR_FLAGS   = 9'h192;
   localparam logic [8:0] OFF_ERR_ENABLE  = 9'h193;
   localparam logic [8:0] OFF_CONTROL     = 9'h195;

   // ----------------------------------------------------------------
   // Top-level flag and enable bit positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_BUS_RESET  = 0;
   localparam int unsigned BIT_AGG_FAULT  = 1;
   localparam int unsigned BIT_ACTIVITY   = 2;
   localparam int unsigned BIT_TOKEN_DONE = 3;
   localparam int unsigned BIT_QUIET      = 4;
   localparam int unsigned BIT_STALL      = 5;
   localparam int unsigned IRQ_BITS       = 6;

   // ----------------------------------------------------------------
   // Error flag bit positions
   // ----------------------------------------------------------------
   localparam int unsigned ERR_PID        = 0;
   localparam int unsigned ERR_CRC5       = 1;
   localparam int unsigned ERR_CRC16      = 2;
   localparam int unsigned ERR_PARTIAL    = 3;
   localparam int unsigned ERR_TURNAROUND = 4;
   localparam int unsigned ERR_COLLISION  = 5;
   localparam int unsigned ERR_OWNERSHIP  = 6;
   localparam int unsigned ERR_STUFFING   = 7;

   // Control register: low-power hold bit
   localparam int unsigned BIT_LOW_POWER_HOLD = 1;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [5:0] RST_IRQ         = 6'h00;
   localparam int unsigned TURNAROUND_BITS = 17;
   localparam int unsigned BIT_COUNT_W     = 5;

endpackage : usb_irq_pkg

// >>> src/usb_interrupt_error_flags.sv
// USB interrupt enable, top-level flags and error-flag logic of a full-speed device function.
// Assumes fault and event pulses come from the transceiver engine on i_clock, one cycle each,
// and a one-cycle bit-time enable; the register port is driven by firmware logic on i_clock.
`timescale 1ns/100ps
`default_nettype none

module usb_interrupt_error_flags #(
   parameter int unsigned TURNAROUND_BITS = usb_irq_pkg::TURNAROUND_BITS
) (
   input  wire logic       i_clock,
   input  wire logic       i_sys_rst,
   // Register port
   input  wire logic [8:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Event pulses from the transceiver engine
   input  wire logic       i_bus_reset_evt,
   input  wire logic       i_activity_evt,
   input  wire logic       i_token_done_evt,
   input  wire logic       i_quiet_evt,
   input  wire logic       i_stall_evt,
   // Fault pulses from the transceiver engine
   input  wire logic       i_stuffing_fault,
   input  wire logic       i_desc_owned_by_cpu,
   input  wire logic       i_token_seen,
   input  wire logic       i_buffer_write_collision,
   input  wire logic       i_partial_byte_fault,
   input  wire logic       i_crc16_fail,
   input  wire logic       i_crc5_fail,
   input  wire logic       i_packet_id_check_fault,
   // Turnaround timing inputs
   input  wire logic       i_bit_tick,
   input  wire logic       i_eop_seen,
   input  wire logic       i_bus_idle,
   // Outputs
   output logic            o_peripheral_usb_request,
   output logic            o_token_rejected,
   output logic            o_cpu_write_failed,
   output logic            o_low_power_hold
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [5:0] usb_irq_enable_reg;
   logic [5:0] usb_irq_flags_reg;
   logic [7:0] usb_error_flags_reg;
   logic [7:0] usb_error_enable_reg;
   logic       low_power_hold_reg;
   logic [7:0] fault_set;
   logic [5:0] irq_set;
   logic       aggregated_fault_flag;
   logic       turnaround_active_reg;
   logic [4:0] turnaround_count_reg;
   logic       turnaround_timeout;
   logic       turnaround_active_next;
   logic [4:0] turnaround_count_next;
   logic [7:0] usb_error_flags_next;
   logic [7:0] usb_error_enable_next;
   logic [5:0] usb_irq_flags_next;
   logic [5:0] usb_irq_enable_next;
   logic [7:0] irq_flags_wide;
   logic [5:0] irq_masked;
   logic       low_power_hold_next;
   logic       request_next;
   logic [7:0] rdata_next;
   logic       err_write_taken;
   logic       irq_write_taken;

   function automatic logic wr_hit(input logic [8:0] offset);
      wr_hit = i_wr && (i_addr == offset);
   endfunction : wr_hit

   // Write-zero-clear with set priority: an event in the cycle of a clear
   // must not be lost, so the set term is applied after the mask.
   function automatic logic [7:0] clear_then_set(
      input logic [7:0] flags,
      input logic [7:0] keep_mask,
      input logic [7:0] set_bits,
      input logic       take_write
   );
      logic [7:0] kept;
      kept = take_write ? (flags & keep_mask) : flags;
      clear_then_set = kept | set_bits;
   endfunction : clear_then_set

   // Top-level registers are six bits wide; the two upper bits always read zero
   function automatic logic [7:0] pad_top(input logic [5:0] bits);
      pad_top = {2'b00, bits};
   endfunction : pad_top

   // ----------------------------------------------------------------
   // Turnaround timer
   // ----------------------------------------------------------------
   // Counts bit times from end-of-packet while the bus stays idle; leaving idle
   // stops the watch, and a new end-of-packet restarts it.
   always_comb begin
      turnaround_active_next = turnaround_active_reg;
      turnaround_count_next  = turnaround_count_reg;
      if (i_eop_seen) begin
         turnaround_active_next = 1'b1;
         turnaround_count_next  = '0;
      end else if (!i_bus_idle || turnaround_timeout) begin
         // Leaving idle in time is the normal turnaround; the watch just stops
         turnaround_active_next = 1'b0;
      end else if (turnaround_active_reg && i_bit_tick) begin
         turnaround_count_next  = turnaround_count_reg + 5'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         turnaround_active_reg <= 1'b0;
         turnaround_count_reg  <= '0;
      end else begin
         turnaround_active_reg <= turnaround_active_next;
         turnaround_count_reg  <= turnaround_count_next;
      end
   end

   // More than the limit means the tick that would pass the limit
   assign turnaround_timeout = turnaround_active_reg && i_bus_idle && i_bit_tick
      && (turnaround_count_reg == TURNAROUND_BITS[4:0]);

   // ----------------------------------------------------------------
   // Error flag sources
   // ----------------------------------------------------------------
   always_comb begin
      fault_set = '0;
      fault_set[usb_irq_pkg::ERR_STUFFING]   = i_stuffing_fault;
      fault_set[usb_irq_pkg::ERR_OWNERSHIP]  = i_token_seen && i_desc_owned_by_cpu;
      fault_set[usb_irq_pkg::ERR_COLLISION]  = i_buffer_write_collision;
      fault_set[usb_irq_pkg::ERR_TURNAROUND] = turnaround_timeout;
      fault_set[usb_irq_pkg::ERR_PARTIAL]    = i_partial_byte_fault;
      fault_set[usb_irq_pkg::ERR_CRC16]      = i_crc16_fail;
      fault_set[usb_irq_pkg::ERR_CRC5]       = i_crc5_fail;
      fault_set[usb_irq_pkg::ERR_PID]        = i_packet_id_check_fault;
   end

   // Flags set immediately; write-zero clears, and a same-cycle fault wins.
   // Writes are refused during low-power hold, but faults still set.
   always_comb begin
      err_write_taken      = wr_hit(usb_irq_pkg::OFF_ERR_FLAGS) && !low_power_hold_reg;
      usb_error_flags_next = clear_then_set(usb_error_flags_reg, i_wdata, fault_set,
         err_write_taken);
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         usb_error_flags_reg <= usb_irq_pkg::RST_BYTE;
      end else begin
         usb_error_flags_reg <= usb_error_flags_next;
      end
   end

   // Enables never gate the error flags themselves, only the aggregated fault
   always_comb begin
      usb_error_enable_next = usb_error_enable_reg;
      if (wr_hit(usb_irq_pkg::OFF_ERR_ENABLE)) begin
         usb_error_enable_next = i_wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         usb_error_enable_reg <= usb_irq_pkg::RST_BYTE;
      end else begin
         usb_error_enable_reg <= usb_error_enable_next;
      end
   end

   assign aggregated_fault_flag = |(usb_error_flags_reg & usb_error_enable_reg);

   // ----------------------------------------------------------------
   // Top-level flags and enables
   // ----------------------------------------------------------------
   always_comb begin
      irq_set = '0;
      irq_set[usb_irq_pkg::BIT_BUS_RESET]  = i_bus_reset_evt;
      irq_set[usb_irq_pkg::BIT_AGG_FAULT]  = aggregated_fault_flag;
      irq_set[usb_irq_pkg::BIT_ACTIVITY]   = i_activity_evt;
      irq_set[usb_irq_pkg::BIT_TOKEN_DONE] = i_token_done_evt;
      irq_set[usb_irq_pkg::BIT_QUIET]      = i_quiet_evt;
      irq_set[usb_irq_pkg::BIT_STALL]      = i_stall_evt;
   end

   // Flags set regardless of enables so firmware can poll them.
   // The aggregated fault re-sets at once while any enabled error flag stands.
   always_comb begin
      irq_write_taken    = wr_hit(usb_irq_pkg::OFF_IRQ_FLAGS) && !low_power_hold_reg;
      irq_flags_wide     = clear_then_set(pad_top(usb_irq_flags_reg), i_wdata,
         pad_top(irq_set), irq_write_taken);
      usb_irq_flags_next = irq_flags_wide[5:0];
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         usb_irq_flags_reg <= usb_irq_pkg::RST_IRQ;
      end else begin
         usb_irq_flags_reg <= usb_irq_flags_next;
      end
   end

   // The two upper write bits have no storage and are dropped on purpose
   always_comb begin
      usb_irq_enable_next = usb_irq_enable_reg;
      if (wr_hit(usb_irq_pkg::OFF_IRQ_ENABLE)) begin
         usb_irq_enable_next = i_wdata[5:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         usb_irq_enable_reg <= usb_irq_pkg::RST_IRQ;
      end else begin
         usb_irq_enable_reg <= usb_irq_enable_next;
      end
   end

   // Only the hold bit of the control register is kept in this block
   always_comb begin
      low_power_hold_next = low_power_hold_reg;
      if (wr_hit(usb_irq_pkg::OFF_CONTROL)) begin
         low_power_hold_next = i_wdata[usb_irq_pkg::BIT_LOW_POWER_HOLD];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         low_power_hold_reg <= 1'b0;
      end else begin
         low_power_hold_reg <= low_power_hold_next;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   // Enables only mask the request path; the flags above are never masked
   always_comb begin
      irq_masked = usb_irq_flags_reg & usb_irq_enable_reg;
      if (low_power_hold_reg) begin
         request_next = irq_masked[usb_irq_pkg::BIT_ACTIVITY];
      end else begin
         request_next = |irq_masked;
      end
   end

   // Registered one cycle after the flag so the output comes from a flip-flop.
   // The extra cycle of latency is traded for a glitch-free request line.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_peripheral_usb_request <= 1'b0;
      end else begin
         o_peripheral_usb_request <= request_next;
      end
   end

   // ----------------------------------------------------------------
   // Side outputs
   // ----------------------------------------------------------------
   // A failing token is dropped by the engine; this pulse tells it so
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_token_rejected <= 1'b0;
      end else begin
         o_token_rejected <= i_crc5_fail;
      end
   end

   // The colliding processor write is not retried here; software must repeat it
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_cpu_write_failed <= 1'b0;
      end else begin
         o_cpu_write_failed <= i_buffer_write_collision;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_low_power_hold <= 1'b0;
      end else begin
         o_low_power_hold <= low_power_hold_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped addresses read zero; reads have no side effects.
   always_comb begin
      rdata_next = usb_irq_pkg::RST_BYTE;
      if (i_rd) begin
         unique case (i_addr)
            usb_irq_pkg::OFF_IRQ_FLAGS:  rdata_next = pad_top(usb_irq_flags_reg);
            usb_irq_pkg::OFF_IRQ_ENABLE: rdata_next = pad_top(usb_irq_enable_reg);
            usb_irq_pkg::OFF_ERR_FLAGS:  rdata_next = usb_error_flags_reg;
            usb_irq_pkg::OFF_ERR_ENABLE: rdata_next = usb_error_enable_reg;
            usb_irq_pkg::OFF_CONTROL:    rdata_next = {6'h00, low_power_hold_reg, 1'b0};
            default:                     rdata_next = usb_irq_pkg::RST_BYTE;
         endcase
      end
   end

   // Data stand for exactly one cycle, so a stale byte is never taken for a read
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_rdata <= usb_irq_pkg::RST_BYTE;
      end else begin
         o_rdata <= rdata_next;
      end
   end

endmodule : usb_interrupt_error_flags

`default_nettype wire

// >>> tb/usb_irq_checker_sva.sv
// Checker: port-level properties of the USB interrupt and error-flag block.
// Assumes the single clock and the synchronous reset of that block.
`timescale 1ns/100ps
`default_nettype none
module usb_irq_checker #(
   parameter int unsigned TURNAROUND_BITS = 17
) (
   input wire logic       i_clock,
   input wire logic       i_sys_rst,
   input wire logic [8:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_crc5_fail,
   input wire logic       i_buffer_write_collision,
   input wire logic       i_stuffing_fault,
   input wire logic       i_crc16_fail,
   input wire logic       o_token_rejected,
   input wire logic       o_cpu_write_failed,
   input wire logic       o_low_power_hold
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   enable_unimpl_a:
   assert property (i_rd && i_addr == usb_irq_pkg::OFF_IRQ_ENABLE |=> o_rdata[7:6] == 2'h0)
      else $error("enable bits 7:6 read nonzero");
   token_reject_a:
   assert property (i_crc5_fail |=> o_token_rejected) else $error("token not rejected");
   reject_only_a:
   assert property (!i_crc5_fail |=> !o_token_rejected) else $error("spurious token reject");
   write_fail_a:
   assert property (i_buffer_write_collision |=> o_cpu_write_failed)
      else $error("collision not reported");
   stuff_flag_a:
   assert property ($past(i_stuffing_fault) && i_rd && i_addr == usb_irq_pkg::OFF_ERR_FLAGS
      |=> o_rdata[7]) else $error("stuffing flag late");
   crc16_flag_a:
   assert property ($past(i_crc16_fail) && i_rd && i_addr == usb_irq_pkg::OFF_ERR_FLAGS
      |=> o_rdata[2]) else $error("crc16 flag late");
   crc5_flag_a:
   assert property ($past(i_crc5_fail) && i_rd && i_addr == usb_irq_pkg::OFF_ERR_FLAGS
      |=> o_rdata[1]) else $error("crc5 flag late");
   hold_follow_a:
   assert property (i_wr && i_addr == usb_irq_pkg::OFF_CONTROL
      |-> ##3 o_low_power_hold == $past(i_wdata[1], 3)) else $error("hold bit wrong");
endmodule : usb_irq_checker
bind usb_interrupt_error_flags usb_irq_checker #(.TURNAROUND_BITS(TURNAROUND_BITS)) chk_inst (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_crc5_fail(i_crc5_fail),
   .i_buffer_write_collision(i_buffer_write_collision), .i_stuffing_fault(i_stuffing_fault),
   .i_crc16_fail(i_crc16_fail), .o_token_rejected(o_token_rejected),
   .o_cpu_write_failed(o_cpu_write_failed), .o_low_power_hold(o_low_power_hold));
`default_nettype wire

// >>> tb/usb_engine_model.sv
// Engine model: makes fault, event and turnaround signals on bench command.
// Assumes one-cycle commands from the bench on the block's clock.
`timescale 1ns/100ps
`default_nettype none
module usb_engine_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_go,
   input  wire logic [3:0] i_sel,
   input  wire logic [5:0] i_ta_n,
   output logic      [7:0] o_fault,
   output logic      [5:0] o_evt,
   output logic            o_eop,
   output logic            o_idle
);
   logic [5:0] left_reg;
   // Faults and events are single-cycle pulses
   always_ff @(posedge i_clock) begin
      o_fault <= 8'h00;
      o_evt <= 6'h00;
      if (!i_rst && i_go && i_sel < 4'h8) o_fault[i_sel[2:0]] <= 1'b1;
      if (!i_rst && i_go && i_sel >= 4'h8) o_evt[i_sel - 4'h8] <= 1'b1;
   end
   // Idle lasts the chosen bit count after end-of-packet, then traffic resumes
   always_ff @(posedge i_clock) begin
      o_eop <= 1'b0;
      if (i_rst) begin
         o_idle <= 1'b0;
         left_reg <= 6'h00;
      end else if (i_go && i_sel == 4'h4) begin
         o_eop <= 1'b1;
         o_idle <= 1'b1;
         left_reg <= i_ta_n;
      end else if (left_reg != 6'h00) left_reg <= left_reg - 6'h01;
      else o_idle <= 1'b0;
   end
endmodule : usb_engine_model
`default_nettype wire

// >>> tb/usb_interrupt_error_flags_tb.sv
// Bench: drives registers and the engine model, compares against an integer model.
// Assumes the byte register port with read data one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module usb_interrupt_error_flags_tb;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [8:0] i_addr = 9'h000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic go = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [5:0] ta_n = 6'h00;
   logic [7:0] rdata, fault;
   logic [5:0] evt;
   logic req, eop, idle, rej, wfail, hold;
   int fails = 0, checks_done = 0, m_err = 0, m_irq = 0, m_en = 0, m_een = 0, m_hold = 0, r;
   always #20 i_clock = ~i_clock;
   usb_engine_model usb_engine_model_inst (.i_clock(i_clock), .i_rst(i_sys_rst), .i_go(go),
      .i_sel(sel), .i_ta_n(ta_n), .o_fault(fault), .o_evt(evt), .o_eop(eop), .o_idle(idle));
   usb_interrupt_error_flags usb_interrupt_error_flags_inst (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .i_bus_reset_evt(evt[0]), .i_activity_evt(evt[2]),
      .i_token_done_evt(evt[3]), .i_quiet_evt(evt[4]), .i_stall_evt(evt[5]),
      .i_stuffing_fault(fault[7]), .i_desc_owned_by_cpu(fault[6]), .i_token_seen(fault[6]),
      .i_buffer_write_collision(fault[5]), .i_partial_byte_fault(fault[3]),
      .i_crc16_fail(fault[2]), .i_crc5_fail(fault[1]), .i_packet_id_check_fault(fault[0]),
      .i_bit_tick(idle), .i_eop_seen(eop), .i_bus_idle(idle), .o_peripheral_usb_request(req),
      .o_token_rejected(rej), .o_cpu_write_failed(wfail), .o_low_power_hold(hold));
   task automatic results;
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic chk(input string nm, input int exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp[7:0]) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp[7:0], got);
      end
   endtask : chk
   // Model updates ride along with each write, so expectations never lag the bus
   task automatic wr(input logic [8:0] a, input int d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d[7:0];
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      if (a == usb_irq_pkg::OFF_ERR_FLAGS && m_hold == 0) m_err &= d;
      if (a == usb_irq_pkg::OFF_IRQ_FLAGS && m_hold == 0) m_irq &= d;
      if (a == usb_irq_pkg::OFF_IRQ_ENABLE) m_en = d & 8'h3F;
      if (a == usb_irq_pkg::OFF_ERR_ENABLE) m_een = d & 8'hFF;
      if (a == usb_irq_pkg::OFF_CONTROL) m_hold = d[1];
      if ((m_err & m_een) != 0) m_irq |= 2;
   endtask : wr
   task automatic rd(input logic [8:0] a, input int exp);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask : rd
   task automatic fire(input int k, input int n);
      @(posedge i_clock);
      sel <= k[3:0];
      ta_n <= n[5:0];
      go <= 1'b1;
      @(posedge i_clock);
      go <= 1'b0;
      if (k < 8 && (k != 4 || n > 17)) m_err |= 1 << k;
      if (k >= 8) m_irq |= 1 << (k - 8);
      if ((m_err & m_een) != 0) m_irq |= 2;
      if (k == 4) repeat (40) @(posedge i_clock);
   endtask : fire
   task automatic req_chk;
      repeat (3) @(posedge i_clock);
      r = m_hold ? (m_irq & m_en & 4) : (m_irq & m_en);
      #1 chk("request", r != 0, {7'h00, req});
   endtask : req_chk
   initial begin
      repeat (5000) @(posedge i_clock);
      fails++;
      results();
   end
   initial begin
      r = $urandom(32'h03e83d14);
      repeat (12) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      for (int a = 9'h190; a < 9'h194; a++) rd(a[8:0], 0);
      rd(9'h1FF, 0);
      repeat (2) begin
         r = $urandom;
         wr(usb_irq_pkg::OFF_ERR_ENABLE, r);
         wr(usb_irq_pkg::OFF_IRQ_ENABLE, r >> 8);
         rd(usb_irq_pkg::OFF_IRQ_ENABLE, m_en);
         rd(usb_irq_pkg::OFF_ERR_ENABLE, m_een);
         for (int k = 0; k < 8; k++) begin
            wr(usb_irq_pkg::OFF_ERR_FLAGS, 0);
            wr(usb_irq_pkg::OFF_IRQ_FLAGS, 0);
            fire(k, 30);
            rd(usb_irq_pkg::OFF_ERR_FLAGS, m_err);
            rd(usb_irq_pkg::OFF_IRQ_FLAGS, m_irq);
            req_chk();
         end
      end
      wr(usb_irq_pkg::OFF_ERR_FLAGS, 8'hFF);
      rd(usb_irq_pkg::OFF_ERR_FLAGS, m_err);
      wr(usb_irq_pkg::OFF_ERR_FLAGS, 0);
      wr(usb_irq_pkg::OFF_IRQ_FLAGS, 0);
      fire(4, 10);
      rd(usb_irq_pkg::OFF_ERR_FLAGS, m_err);
      wr(usb_irq_pkg::OFF_IRQ_ENABLE, 0);
      for (int k = 8; k < 14; k++) if (k != 9) fire(k, 0);
      rd(usb_irq_pkg::OFF_IRQ_FLAGS, m_irq);
      req_chk();
      repeat (4) begin
         wr(usb_irq_pkg::OFF_IRQ_ENABLE, $urandom);
         req_chk();
      end
      wr(usb_irq_pkg::OFF_IRQ_FLAGS, 8'h3B);
      wr(usb_irq_pkg::OFF_IRQ_ENABLE, 8'h3F);
      wr(usb_irq_pkg::OFF_CONTROL, 2);
      req_chk();
      fire(2, 0);
      wr(usb_irq_pkg::OFF_ERR_FLAGS, 0);
      rd(usb_irq_pkg::OFF_ERR_FLAGS, m_err);
      fire(10, 0);
      req_chk();
      wr(usb_irq_pkg::OFF_CONTROL, 0);
      results();
   end
endmodule : usb_interrupt_error_flags_tb
`default_nettype wire
